// [hw/adc_aux_crc_syscal_regs.sv]
// How it works
// - a 0xC3 reset command clears the channel offset and gain coefficients only when the clear-on-reset bit is 1.
// - the external clock detect bypass bit resets to 0 so detection runs, and 1 bypasses it.
// - the clock select bit counts only while detection is bypassed, 0 internal and 1 external.
// - excitation codes 0x0 to 0xA give 0 to 1000 uA in 100 uA steps.
// - the CRC enable bit resets to 0 and enables CRC over conversion byte reads when 1.
// - with release-after-crc at 0, data ready goes high once the low conversion byte is read.
// - with release-after-crc at 1, data ready stays low until the CRC byte after the low byte is read.
// - the 16-bit diagnostic threshold is split high byte at 0x14 and low byte at 0x15.
// - writing the calibration field picks normal, offset or gain determination, 0x3 is not written.
// - reading the calibration field returns the mode in progress.
// - a determination ends with one conversion and the field falls back to normal.
// - the CRC is cleared when data ready is released unless the disable bit is 1.
// - writing the CRC data register clears the CRC and reading it returns the CRC byte.
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ns
`include "regs_map.svh"

module adc_aux_crc_syscal_regs (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // converter side
  input wire logic i_conv_done,
  input wire logic [23:0] i_conv_data,
  input wire logic [1:0] i_conv_channel,
  input wire logic i_ext_clk_present,
  input wire logic [2:0] i_coeff_rd_addr,
  // controls and status
  output logic o_data_ready_n,
  output logic o_ext_clk_select,
  output logic [9:0] o_excitation_current_ua,
  output logic [15:0] o_diag_threshold,
  output logic [1:0] o_syscal_mode,
  output logic o_crc_enable,
  output logic o_conv_reset,
  output regs_pkg::coeff_t o_coeff_rd_data
);

  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [7:0] aux_q;
  logic [7:0] aux_d;
  logic [7:0] crc_cn_q;
  logic [7:0] crc_cn_d;
  logic [7:0] crc_opt_q;
  logic [7:0] crc_opt_d;
  logic [15:0] thld_q;
  logic [15:0] thld_d;
  regs_pkg::syscal_mode_e mode_q;
  regs_pkg::syscal_mode_e mode_d;
  logic [23:0] conv_q;
  logic drdy_n_q;
  logic drdy_n_d;
  logic low_read_q;
  logic low_read_d;
  logic ext_sel_q;
  logic [9:0] cur_q;
  logic conv_rst_q;
  logic [7:0] crc_val;

  function automatic logic [7:0] wmask(input logic [7:0] cur,
                                       input logic [7:0] wd,
                                       input logic [7:0] m);
    return (cur & ~m) | (wd & m);
  endfunction : wmask

  function automatic logic [9:0] code_to_ua(input logic [3:0] code);
    return (code <= `CUR_MAX_CODE) ? 10'({6'h00, code} * `CUR_STEP_UA)
                                   : 10'h000;
  endfunction : code_to_ua

  // bus decode
  wire [5:0] idx = i_paddr[7:2];
  wire acc = i_psel & i_penable & pready_q;
  wire wr = acc & i_pwrite;
  wire rd = acc & ~i_pwrite;
  wire first_acc = i_psel & i_penable & ~pready_q;
  wire [7:0] wbyte = i_pwdata[7:0];

  wire sel_rst = idx == `IDX_RESET_CMD;
  wire sel_opt = idx == `IDX_CRC_OPT;
  wire sel_aux = idx == `IDX_AUX;
  wire sel_cn = idx == `IDX_CRC_CN;
  wire sel_th = idx == `IDX_THLD_H;
  wire sel_tl = idx == `IDX_THLD_L;
  wire sel_cal = idx == `IDX_SYSCAL;
  wire sel_ch = idx == `IDX_CONV_H;
  wire sel_cm = idx == `IDX_CONV_M;
  wire sel_cl = idx == `IDX_CONV_L;
  wire sel_cd = idx == `IDX_CRC_DAT;
  wire sel_conv = sel_ch | sel_cm | sel_cl;
  wire mapped = sel_rst | sel_opt | sel_aux | sel_cn | sel_th | sel_tl |
                sel_cal | sel_conv | sel_cd;

  // read selection, reserved bits read zero
  wire [7:0] rbyte =
    sel_opt ? crc_opt_q :
    sel_aux ? aux_q :
    sel_cn ? crc_cn_q :
    sel_th ? thld_q[15:8] :
    sel_tl ? thld_q[7:0] :
    sel_cal ? {6'h00, mode_q} :
    sel_ch ? conv_q[23:16] :
    sel_cm ? conv_q[15:8] :
    sel_cl ? conv_q[7:0] :
    sel_cd ? crc_val :
    8'h00;

  // soft reset command
  wire cmd_hit = wr & sel_rst & (wbyte == `RESET_CMD_VAL);
  wire mem_clear = cmd_hit & aux_q[`AUX_CLR_BIT];

  // configuration registers
  assign aux_d = cmd_hit ? `AUX_RST :
                 (wr & sel_aux) ? (wbyte & `AUX_MASK) : aux_q;
  // bit 3 is never stored, host keeps it zero
  assign crc_cn_d = cmd_hit ? `CRC_CN_RST :
                    (wr & sel_cn) ? (wbyte & `CRC_CN_MASK) : crc_cn_q;
  assign crc_opt_d = cmd_hit ? `CRC_OPT_RST :
                     (wr & sel_opt) ? (wbyte & `CRC_OPT_MASK) : crc_opt_q;
  assign thld_d = cmd_hit ? `THLD_RST :
                  {(wr & sel_th) ? wbyte : thld_q[15:8],
                   (wr & sel_tl) ? wbyte : thld_q[7:0]};

  wire crc_en = crc_cn_q[`CRC_EN_BIT];
  wire aft_crc = crc_cn_q[`CRC_AFT_BIT];
  wire crc_norst = crc_opt_q[`CRC_NORST_BIT];

  // system calibration mode
  wire cal_wr = wr & sel_cal & (wbyte[1:0] != 2'h3);
  wire cal_busy = mode_q != regs_pkg::SYSCAL_NORMAL;
  wire cal_finish = cal_busy & i_conv_done;
  assign mode_d = cmd_hit ? regs_pkg::SYSCAL_NORMAL :
                  cal_wr ? regs_pkg::syscal_mode_e'(wbyte[1:0]) :
                  cal_finish ? regs_pkg::SYSCAL_NORMAL : mode_q;
  wire [2:0] coeff_waddr = {mode_q == regs_pkg::SYSCAL_GAIN, i_conv_channel};

  // data ready release
  wire rel_low = rd & sel_cl & ~aft_crc;
  wire rel_crc = rd & sel_cd & aft_crc & low_read_q;
  wire release_now = ~drdy_n_q & (rel_low | rel_crc);
  // a new conversion wins over a release in the same cycle
  assign drdy_n_d = i_conv_done ? 1'b0 :
                    (release_now | cmd_hit) ? 1'b1 : drdy_n_q;
  wire drdy_rise = ~drdy_n_q & drdy_n_d;
  assign low_read_d = (i_conv_done | drdy_rise) ? 1'b0 :
                      (rd & sel_cl & aft_crc) ? 1'b1 : low_read_q;

  // crc over conversion bytes read by the host
  wire crc_clear = (drdy_rise & ~crc_norst) | (wr & sel_cd) | cmd_hit;
  wire crc_feed = rd & sel_conv & crc_en;

  crc8_unit u_crc (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clear(crc_clear),
    .i_feed(crc_feed),
    .i_byte(rbyte),
    .o_crc(crc_val)
  );

  cal_coeff_mem u_mem (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clear(mem_clear),
    .i_we(cal_finish),
    .i_waddr(coeff_waddr),
    .i_wdata(i_conv_data),
    .i_raddr(i_coeff_rd_addr),
    .o_rdata(o_coeff_rd_data)
  );

  // clock source: detection result unless bypassed
  wire ext_sel_d = aux_q[`AUX_BYP_BIT] ? aux_q[`AUX_SEL_BIT]
                                       : i_ext_clk_present;

  // apb handshake: one wait state so read data comes from a flop
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= first_acc;
      if (first_acc) begin
        pslverr_q <= ~mapped;
        prdata_q <= {24'h000000, rbyte};
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aux_q <= `AUX_RST;
      crc_cn_q <= `CRC_CN_RST;
      crc_opt_q <= `CRC_OPT_RST;
      thld_q <= `THLD_RST;
      mode_q <= regs_pkg::SYSCAL_NORMAL;
    end else begin
      aux_q <= aux_d;
      crc_cn_q <= crc_cn_d;
      crc_opt_q <= crc_opt_d;
      thld_q <= thld_d;
      mode_q <= mode_d;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      conv_q <= 24'h000000;
      drdy_n_q <= 1'b1;
      low_read_q <= 1'b0;
      ext_sel_q <= 1'b0;
      cur_q <= 10'h000;
      conv_rst_q <= 1'b0;
    end else begin
      if (i_conv_done) begin
        conv_q <= i_conv_data;
      end
      drdy_n_q <= drdy_n_d;
      low_read_q <= low_read_d;
      ext_sel_q <= ext_sel_d;
      cur_q <= code_to_ua(aux_q[3:0]);
      conv_rst_q <= cmd_hit;
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_data_ready_n = drdy_n_q;
  assign o_ext_clk_select = ext_sel_q;
  assign o_excitation_current_ua = cur_q;
  assign o_diag_threshold = thld_q;
  assign o_syscal_mode = mode_q;
  assign o_crc_enable = crc_cn_q[`CRC_EN_BIT];
  assign o_conv_reset = conv_rst_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  drdy_release_a: assert property (
    rel_low & ~drdy_n_q & ~i_conv_done |=> o_data_ready_n ##1 o_pready == 1'b0)
    else $error("data ready not released after low byte read");
  drdy_hold_a: assert property (
    rd & sel_cl & aft_crc & ~drdy_n_q & ~i_conv_done |=> ~o_data_ready_n)
    else $error("data ready released before crc byte read");
  cal_rsvd_a: assert property (
    wr & sel_cal & (wbyte[1:0] == 2'h3) & ~i_conv_done |=> $stable(mode_q))
    else $error("reserved calibration code changed the mode");
  cal_done_a: assert property (
    cal_finish & ~(wr & (sel_cal | sel_rst)) |=>
      o_syscal_mode == 2'h0 &&
      u_mem.mem_q[$past(coeff_waddr)] == $past(i_conv_data))
    else $error("calibration mode did not end after one conversion");
  crc_wrclr_a: assert property (
    wr & sel_cd |=> crc_val == 8'h00)
    else $error("crc not cleared by data register write");
  cal_clear_a: assert property (
    cmd_hit & aux_q[`AUX_CLR_BIT] & ~cal_finish |->
      ##2 (o_coeff_rd_data == 24'h000000 || $past(cal_finish)))
    else $error("coefficients survived a clearing reset command");
  clk_bypass_a: assert property (
    aux_q[`AUX_BYP_BIT] |=> o_ext_clk_select == $past(aux_q[`AUX_SEL_BIT]))
    else $error("clock select ignored while detection bypassed");
  cur_map_a: assert property (
    aux_q[3:0] == 4'hA |=> o_excitation_current_ua == 10'h3E8)
    else $error("top excitation code not 1000 uA");
  cur_undef_a: assert property (
    aux_q[3:0] > 4'hA |=> o_excitation_current_ua == 10'h000)
    else $error("undefined excitation code drives current");
  crc_auto_a: assert property (
    $rose(drdy_n_q) & ~$past(crc_norst) & ~$past(cmd_hit) |-> crc_val == 8'h00)
    else $error("crc not cleared on data ready release");
  crc_off_a: assert property (
    rd & sel_conv & ~crc_en & ~crc_clear |=> $stable(crc_val))
    else $error("crc updated while disabled");
  thld_write_a: assert property (
    wr & sel_th & ~cmd_hit |=> o_diag_threshold[15:8] == $past(wbyte))
    else $error("threshold high byte not stored");
  cal_read_a: assert property (
    first_acc & ~i_pwrite & sel_cal |=> o_prdata[1:0] == $past(mode_q))
    else $error("calibration read does not show current mode");

  rel_low_c: cover property (rel_low & ~drdy_n_q ##1 o_data_ready_n);
  rel_crc_c: cover property (rel_crc & ~drdy_n_q ##1 o_data_ready_n);
  cal_end_c: cover property (cal_wr ##[1:50] cal_finish);
  rst_cmd_c: cover property (mem_clear);

endmodule : adc_aux_crc_syscal_regs

// [hw/cal_coeff_mem.sv]
`timescale 1ns/1ns

module cal_coeff_mem (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // write and clear
  input wire logic i_clear,
  input wire logic i_we,
  input wire logic [2:0] i_waddr,
  input wire regs_pkg::coeff_t i_wdata,
  // read
  input wire logic [2:0] i_raddr,
  output regs_pkg::coeff_t o_rdata
);

  regs_pkg::coeff_t mem_q [8];
  regs_pkg::coeff_t rdata_q;

  assign o_rdata = rdata_q;

  // flops, not a ram macro: a clear must wipe all words in one cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 8; i++) begin
        mem_q[i] <= 24'h000000;
      end
    end else if (i_clear) begin
      for (int i = 0; i < 8; i++) begin
        mem_q[i] <= 24'h000000;
      end
    end else if (i_we) begin
      mem_q[i_waddr] <= i_wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q <= 24'h000000;
    end else begin
      rdata_q <= mem_q[i_raddr];
    end
  end

endmodule : cal_coeff_mem

// [hw/crc8_unit.sv]
`timescale 1ns/1ns
`include "regs_map.svh"

module crc8_unit (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // control
  input wire logic i_clear,
  input wire logic i_feed,
  input wire logic [7:0] i_byte,
  // result
  output logic [7:0] o_crc
);

  logic [7:0] crc_q;
  logic [7:0] crc_d;

  function automatic logic [7:0] crc_step(input logic [7:0] crc,
                                          input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ `CRC_POLY) : {c[6:0], 1'b0};
    end
    return c;
  endfunction : crc_step

  // clear beats a byte fed in the same cycle
  assign crc_d = i_clear ? 8'h00 : (i_feed ? crc_step(crc_q, i_byte) : crc_q);
  assign o_crc = crc_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      crc_q <= 8'h00;
    end else begin
      crc_q <= crc_d;
    end
  end

endmodule : crc8_unit

// [hw/regs_map.svh]
`ifndef REGS_MAP_SVH
`define REGS_MAP_SVH

// register indices, byte address is four times the index
`define IDX_RESET_CMD 6'h00
`define IDX_CRC_OPT 6'h11
`define IDX_AUX 6'h12
`define IDX_CRC_CN 6'h13
`define IDX_THLD_H 6'h14
`define IDX_THLD_L 6'h15
`define IDX_SYSCAL 6'h17
`define IDX_CONV_H 6'h1A
`define IDX_CONV_M 6'h1B
`define IDX_CONV_L 6'h1C
`define IDX_CRC_DAT 6'h1D

// field positions
`define AUX_CLR_BIT 6
`define AUX_BYP_BIT 5
`define AUX_SEL_BIT 4
`define CRC_EN_BIT 4
`define CRC_AFT_BIT 2
`define CRC_NORST_BIT 5

// writable bit masks, everything else reads zero
`define AUX_MASK 8'h7F
`define CRC_CN_MASK 8'h14
`define CRC_OPT_MASK 8'h20

// reset values
`define AUX_RST 8'h00
`define CRC_CN_RST 8'h00
`define CRC_OPT_RST 8'h00
`define THLD_RST 16'h0000

// constants
`define RESET_CMD_VAL 8'hC3
`define CUR_STEP_UA 10'h064
`define CUR_MAX_CODE 4'hA
`define CRC_POLY 8'h31

`endif

// [hw/regs_pkg.sv]
package regs_pkg;

  typedef enum logic [1:0] {
    SYSCAL_NORMAL,
    SYSCAL_OFFSET,
    SYSCAL_GAIN,
    SYSCAL_RSVD
  } syscal_mode_e;

  typedef logic [23:0] coeff_t;

endpackage : regs_pkg

// [test/apb_host_model.sv]
`timescale 1ns/1ns
`include "regs_map.svh"

module apb_host_model (
  // clock
  input wire logic i_clk,
  // apb request
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata,
  // apb answer
  input wire logic i_pready
);
  initial begin
    o_psel = 1'h0;
    o_penable = 1'h0;
    o_pwrite = 1'h0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0000_0000;
  end

  // one transfer; waits on the slave, bounded so a dead slave cannot hang
  task automatic xfer(input logic wr, input logic [5:0] idx,
                      input logic [7:0] d, output logic hung);
    logic [7:0] wd;
    int n;
    wd = d;
    if (wr && idx == `IDX_CRC_CN) wd[3] = 1'h0;
    n = 0;
    @(posedge i_clk);
    o_psel <= 1'h1;
    o_pwrite <= wr;
    o_paddr <= {idx, 2'h0};
    o_pwdata <= {24'h00_0000, wd};
    @(posedge i_clk);
    o_penable <= 1'h1;
    // pready is looked at on the rising edge, as the slave sees it
    @(posedge i_clk);
    while (i_pready !== 1'h1 && n < 64) begin
      @(posedge i_clk);
      n++;
    end
    hung = (i_pready !== 1'h1);
    o_psel <= 1'h0;
    o_penable <= 1'h0;
  endtask : xfer
endmodule : apb_host_model

// [test/test_adc_aux_crc_syscal_regs.sv]
`timescale 1ns/1ns
`include "regs_map.svh"

module test_adc_aux_crc_syscal_regs;
  typedef struct packed {
    logic chk;
    logic err;
    logic [31:0] data;
  } note_s;
  logic i_clk;
  logic i_rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic conv_done;
  logic [23:0] conv_data;
  logic [1:0] conv_ch;
  logic ext_present;
  logic [2:0] coeff_addr;
  logic ready_n;
  logic ext_sel;
  logic [9:0] cur_ua;
  logic [15:0] thr_out;
  logic [1:0] mode_out;
  logic crc_en;
  logic conv_rst;
  regs_pkg::coeff_t coeff;
  note_s notes[$];
  note_s cur;
  int miscompares;
  int samples_checked;
  logic hung;
  logic [7:0] crc;
  logic [23:0] d;
  logic [23:0] cd[3];
  logic [15:0] thr;

  initial begin
    i_clk = 1'h0;
    forever #25 i_clk = ~i_clk;
  end

  apb_host_model host (.i_clk(i_clk), .o_psel(psel), .o_penable(penable),
    .o_pwrite(pwrite), .o_paddr(paddr), .o_pwdata(pwdata),
    .i_pready(pready));

  adc_aux_crc_syscal_regs DUT (.i_clk(i_clk), .i_rst(i_rst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_conv_done(conv_done),
    .i_conv_data(conv_data), .i_conv_channel(conv_ch),
    .i_ext_clk_present(ext_present), .i_coeff_rd_addr(coeff_addr),
    .o_data_ready_n(ready_n), .o_ext_clk_select(ext_sel),
    .o_excitation_current_ua(cur_ua), .o_diag_threshold(thr_out),
    .o_syscal_mode(mode_out), .o_crc_enable(crc_en),
    .o_conv_reset(conv_rst), .o_coeff_rd_data(coeff));

  task automatic check_val(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check_val

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // for a read, d is the expected byte
  task automatic bus(input logic wr, input logic [5:0] idx,
                     input logic [7:0] d, input logic err);
    notes.push_back('{!wr, err, {24'h00_0000, d}});
    host.xfer(wr, idx, d, hung);
    if (hung) begin
      miscompares++;
      tally_and_finish();
    end
  endtask : bus

  // results taken mid-cycle, where registered outputs are settled
  always @(negedge i_clk) begin
    if (psel && penable && pready === 1'h1) begin
      if (notes.size() == 0) begin
        miscompares++;
      end else begin
        cur = notes.pop_front();
        check_val("pslverr", {31'h0, cur.err}, {31'h0, pslverr});
        if (cur.chk) check_val("prdata", cur.data, prdata);
      end
    end
  end

  task automatic settle;
    repeat (2) @(negedge i_clk);
  endtask : settle

  task automatic conv(input logic [23:0] v, input logic [1:0] ch);
    @(posedge i_clk);
    conv_done <= 1'h1;
    conv_data <= v;
    conv_ch <= ch;
    @(posedge i_clk);
    conv_done <= 1'h0;
    settle();
  endtask : conv

  function automatic logic [7:0] crc8(input logic [7:0] c,
                                     input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ({r[6:0], 1'h0} ^ `CRC_POLY) : {r[6:0], 1'h0};
    end
    return r;
  endfunction : crc8

  // reads high, middle, low bytes; ready must hold until the low byte
  task automatic read_conv(input logic [23:0] v);
    crc = 8'h00;
    for (int b = 2; b >= 0; b--) begin
      check_val("ready_n", 32'h0, 32'(ready_n));
      bus(1'h0, `IDX_CONV_H + 6'(2 - b), v[b*8 +: 8], 1'h0);
      crc = crc8(crc, v[b*8 +: 8]);
    end
    @(negedge i_clk);
  endtask : read_conv

  task automatic coeff_check(input logic [23:0] e1, input logic [23:0] e2);
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clk);
      coeff_addr <= (k == 1) ? 3'h6 : 3'h1;
      settle();
      check_val("coeff", 32'(k == 1 ? e2 : e1), 32'(coeff));
    end
  endtask : coeff_check

  initial begin
    i_rst = 1'h1;
    conv_done = 1'h0;
    conv_data = 24'h00_0000;
    conv_ch = 2'h0;
    ext_present = 1'h0;
    coeff_addr = 3'h0;
    miscompares = 0;
    samples_checked = 0;
    void'($urandom(32'hBE04E96B));
    repeat (12) @(posedge i_clk);
    i_rst <= 1'h0;
    @(negedge i_clk);
    check_val("ready_n", 32'h1, 32'(ready_n));
    check_val("ext_sel", 32'h0, 32'(ext_sel));
    check_val("crc_en", 32'h0, 32'(crc_en));
    bus(1'h0, `IDX_AUX, `AUX_RST, 1'h0);
    bus(1'h0, `IDX_CRC_CN, `CRC_CN_RST, 1'h0);
    bus(1'h0, `IDX_SYSCAL, 8'h00, 1'h0);
    bus(1'h0, 6'h30, 8'h00, 1'h1);
    bus(1'h1, 6'h30, 8'h5A, 1'h1);
    bus(1'h1, `IDX_AUX, 8'hFF, 1'h0);
    bus(1'h0, `IDX_AUX, 8'h7F, 1'h0);
    // bypass+external, bypass+internal, detection with no clock and clock
    for (int k = 0; k < 4; k++) begin
      @(posedge i_clk);
      ext_present <= (k == 1 || k == 3);
      bus(1'h1, `IDX_AUX, (k == 3) ? 8'h00 : 8'h30 - 8'(k * 16), 1'h0);
      settle();
      check_val("ext_sel", 32'(k == 0 || k == 3), 32'(ext_sel));
    end
    for (int c = 0; c < 16; c++) begin
      bus(1'h1, `IDX_AUX, 8'(c), 1'h0);
      settle();
      check_val("current", (c <= 10) ? c * 100 : 0, 32'(cur_ua));
    end
    bus(1'h1, `IDX_CRC_CN, 8'hFF, 1'h0);
    bus(1'h0, `IDX_CRC_CN, 8'h14, 1'h0);
    check_val("crc_en", 32'h1, 32'(crc_en));
    thr = 16'($urandom);
    bus(1'h1, `IDX_THLD_H, thr[15:8], 1'h0);
    bus(1'h1, `IDX_THLD_L, thr[7:0], 1'h0);
    bus(1'h0, `IDX_THLD_H, thr[15:8], 1'h0);
    bus(1'h0, `IDX_THLD_L, thr[7:0], 1'h0);
    settle();
    check_val("threshold", 32'(thr), 32'(thr_out));
    for (int m = 1; m < 3; m++) begin
      cd[m] = 24'($urandom);
      bus(1'h1, `IDX_SYSCAL, 8'(m), 1'h0);
      bus(1'h0, `IDX_SYSCAL, 8'(m), 1'h0);
      check_val("mode", 32'(m), 32'(mode_out));
      conv(cd[m], 2'(m));
      bus(1'h0, `IDX_SYSCAL, 8'h00, 1'h0);
    end
    bus(1'h1, `IDX_SYSCAL, 8'h03, 1'h0);
    bus(1'h0, `IDX_SYSCAL, 8'h00, 1'h0);
    coeff_check(cd[1], cd[2]);
    bus(1'h1, `IDX_AUX, 8'h3A, 1'h0);
    bus(1'h1, `IDX_RESET_CMD, `RESET_CMD_VAL, 1'h0);
    @(negedge i_clk);
    check_val("conv_reset", 32'h1, 32'(conv_rst));
    bus(1'h0, `IDX_AUX, 8'h00, 1'h0);
    check_val("ready_n", 32'h1, 32'(ready_n));
    coeff_check(cd[1], cd[2]);
    bus(1'h1, `IDX_AUX, 8'h40, 1'h0);
    bus(1'h1, `IDX_RESET_CMD, `RESET_CMD_VAL, 1'h0);
    coeff_check(24'h00_0000, 24'h00_0000);
    // release on the low byte, crc auto-cleared at release
    bus(1'h1, `IDX_CRC_CN, 8'h10, 1'h0);
    d = 24'($urandom);
    conv(d, 2'h0);
    read_conv(d);
    check_val("ready_n", 32'h1, 32'(ready_n));
    bus(1'h0, `IDX_CRC_DAT, 8'h00, 1'h0);
    // release on the crc byte, auto-clear disabled
    bus(1'h1, `IDX_CRC_OPT, 8'h20, 1'h0);
    bus(1'h1, `IDX_CRC_CN, 8'h14, 1'h0);
    bus(1'h1, `IDX_CRC_DAT, 8'hA5, 1'h0);
    d = 24'($urandom);
    conv(d, 2'h3);
    read_conv(d);
    check_val("ready_n", 32'h0, 32'(ready_n));
    bus(1'h0, `IDX_CRC_DAT, crc, 1'h0);
    @(negedge i_clk);
    check_val("ready_n", 32'h1, 32'(ready_n));
    bus(1'h0, `IDX_CRC_DAT, crc, 1'h0);
    bus(1'h1, `IDX_CRC_DAT, 8'h00, 1'h0);
    bus(1'h0, `IDX_CRC_DAT, 8'h00, 1'h0);
    // crc disabled: a conversion byte read must not feed it
    bus(1'h1, `IDX_CRC_CN, 8'h00, 1'h0);
    bus(1'h0, `IDX_CONV_L, d[7:0], 1'h0);
    bus(1'h0, `IDX_CRC_DAT, 8'h00, 1'h0);
    check_val("crc_en", 32'h0, 32'(crc_en));
    tally_and_finish();
  end
endmodule : test_adc_aux_crc_syscal_regs
